// ---- rpdb_buffer.sv ----
// Packet data buffer: RAM, start offsets, modem pointers and host access port
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module rpdb_buffer (
	// Clock and reset
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	// Register port
	input  wire rpdb_pkg::rpdb_bus_type        i_bus,
	output logic [rpdb_pkg::RPDB_DATA_W-1:0]   o_rd_data,
	// Receive byte stream from modem
	input  wire rpdb_pkg::rpdb_rx_type         i_rx,
	output logic                               o_rx_ready,
	// Transmit byte stream to modem
	output logic                               o_tx_valid,
	output logic [rpdb_pkg::RPDB_DATA_W-1:0]   o_tx_data,
	input  wire logic                          i_tx_ready
);

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic code_legal(input logic [2:0] code);
		code_legal = (code <= rpdb_pkg::RPDB_CODE_SLEEP);
	endfunction

	function automatic rpdb_pkg::rpdb_mode_type code_mode(input logic [2:0] code);
		unique case (code)
			rpdb_pkg::RPDB_CODE_RX_ONE: code_mode = rpdb_pkg::RPDB_RX_ONE;
			rpdb_pkg::RPDB_CODE_RX_CONT: code_mode = rpdb_pkg::RPDB_RX_CONT;
			rpdb_pkg::RPDB_CODE_TX: code_mode = rpdb_pkg::RPDB_TX;
			rpdb_pkg::RPDB_CODE_SLEEP: code_mode = rpdb_pkg::RPDB_SLEEP;
			default: code_mode = rpdb_pkg::RPDB_STANDBY;
		endcase
	endfunction

	function automatic logic [2:0] mode_code(input rpdb_pkg::rpdb_mode_type m);
		unique case (m)
			rpdb_pkg::RPDB_STANDBY: mode_code = rpdb_pkg::RPDB_CODE_STANDBY;
			rpdb_pkg::RPDB_RX_ONE: mode_code = rpdb_pkg::RPDB_CODE_RX_ONE;
			rpdb_pkg::RPDB_RX_CONT: mode_code = rpdb_pkg::RPDB_CODE_RX_CONT;
			rpdb_pkg::RPDB_TX: mode_code = rpdb_pkg::RPDB_CODE_TX;
			rpdb_pkg::RPDB_SLEEP: mode_code = rpdb_pkg::RPDB_CODE_SLEEP;
		endcase
	endfunction

	function automatic logic is_rx(input rpdb_pkg::rpdb_mode_type m);
		is_rx = (m == rpdb_pkg::RPDB_RX_ONE) || (m == rpdb_pkg::RPDB_RX_CONT);
	endfunction

	// ****************************************
	// Storage
	// ****************************************
	logic [rpdb_pkg::RPDB_DATA_W-1:0] mem [rpdb_pkg::RPDB_DEPTH];
	rpdb_pkg::rpdb_state_type         state_reg;
	rpdb_pkg::rpdb_state_type         state_next;
	logic                             mem_we;
	logic [rpdb_pkg::RPDB_PTR_W-1:0]  mem_waddr;
	logic [rpdb_pkg::RPDB_DATA_W-1:0] mem_wdata;
	logic                             host_wr;
	logic                             host_rd;
	logic                             data_wr;
	logic                             data_rd;
	logic                             asleep;
	logic                             rx_take;
	logic                             tx_take;

	assign host_wr = i_bus.wr;
	assign host_rd = i_bus.rd;
	assign asleep  = (state_reg.mode == rpdb_pkg::RPDB_SLEEP);
	assign data_wr = host_wr && (i_bus.addr == rpdb_pkg::RPDB_BUF_DATA_OFS) && !asleep;
	assign data_rd = host_rd && (i_bus.addr == rpdb_pkg::RPDB_BUF_DATA_OFS) && !asleep;

	// Host store owns the single write port; the modem is held off for that cycle
	assign o_rx_ready = is_rx(state_reg.mode) && !data_wr; // see RULE_17
	assign rx_take    = o_rx_ready && i_rx.valid;
	assign o_tx_valid = (state_reg.mode == rpdb_pkg::RPDB_TX) && (state_reg.tx_sent != state_reg.tx_count);
	assign tx_take    = o_tx_valid && i_tx_ready;
	assign o_tx_data  = state_reg.tx_data;
	assign o_rd_data  = state_reg.rd_data;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		state_next = state_reg;
		state_next.rd_data = '0;
		mem_we = 1'b0;
		mem_waddr = state_reg.buf_ptr;
		mem_wdata = i_bus.wdata;

		// Register writes
		if (host_wr && !asleep) begin
			unique case (i_bus.addr)
				rpdb_pkg::RPDB_TX_START_OFS: state_next.tx_start = i_bus.wdata; // see RULE_10
				rpdb_pkg::RPDB_RX_START_OFS: state_next.rx_start = i_bus.wdata; // see RULE_10
				rpdb_pkg::RPDB_TX_COUNT_OFS: state_next.tx_count = i_bus.wdata;
				rpdb_pkg::RPDB_BUF_OFS_OFS: state_next.buf_ptr = i_bus.wdata; // see RULE_12
				default: begin
				end
			endcase
		end

		// Host store: offset picks the byte, then the pointer steps
		if (data_wr) begin
			mem_we = 1'b1; // see RULE_12
			state_next.buf_ptr = state_reg.buf_ptr + 8'h01; // see RULE_13
		end

		// Register reads, data valid in the next cycle only
		if (host_rd) begin
			unique case (i_bus.addr)
				rpdb_pkg::RPDB_TX_START_OFS: state_next.rd_data = state_reg.tx_start;
				rpdb_pkg::RPDB_RX_START_OFS: state_next.rd_data = state_reg.rx_start;
				rpdb_pkg::RPDB_TX_COUNT_OFS: state_next.rd_data = state_reg.tx_count;
				rpdb_pkg::RPDB_MODE_OFS: state_next.rd_data = {5'h00, mode_code(state_reg.mode)};
				rpdb_pkg::RPDB_RX_PKT_OFS: state_next.rd_data = state_reg.rx_pkt_start; // see RULE_05
				rpdb_pkg::RPDB_RX_COUNT_OFS: state_next.rd_data = state_reg.rx_len; // see RULE_05
				rpdb_pkg::RPDB_BUF_OFS_OFS: state_next.rd_data = state_reg.buf_ptr;
				rpdb_pkg::RPDB_BUF_DATA_OFS: begin
					// Sleeping RAM answers zero and the pointer stays put
					if (data_rd) begin
						state_next.rd_data = mem[state_reg.buf_ptr]; // see RULE_01
						state_next.buf_ptr = state_reg.buf_ptr + 8'h01; // see RULE_13
					end
				end
				rpdb_pkg::RPDB_STATUS_OFS: begin
					state_next.rd_data = {2'h0, state_reg.rx_in_pkt, state_reg.rx_done,
						state_reg.tx_done, mode_code(state_reg.mode)};
					state_next.rx_done = 1'b0;
					state_next.tx_done = 1'b0;
				end
				default: state_next.rd_data = '0;
			endcase
		end

		// Receive: every byte is kept, good check or not, wrapping at the top
		if (rx_take) begin
			mem_we = 1'b1; // see RULE_02
			mem_waddr = state_reg.rx_index; // see RULE_15
			mem_wdata = i_rx.data;
			state_next.rx_index = state_reg.rx_index + 8'h01; // see RULE_06
			if (!state_reg.rx_in_pkt) begin
				state_next.rx_pkt_start = state_reg.rx_index; // see RULE_05
				state_next.rx_len = 8'h01;
			end else begin
				// No guard against running into the transmit area
				state_next.rx_len = state_reg.rx_len + 8'h01; // see RULE_16
			end
			state_next.rx_in_pkt = !i_rx.last; // see RULE_04
			if (i_rx.last) begin
				state_next.rx_done = 1'b1;
				if (state_reg.mode == rpdb_pkg::RPDB_RX_ONE) begin
					state_next.mode = rpdb_pkg::RPDB_STANDBY;
				end
			end
		end

		// Transmit: step per byte sent, stop at the byte count
		if (state_reg.mode == rpdb_pkg::RPDB_TX) begin
			if (tx_take) begin
				state_next.tx_index = state_reg.tx_index + 8'h01; // see RULE_07
				state_next.tx_sent = state_reg.tx_sent + 8'h01;
			end
			if (state_reg.tx_sent == state_reg.tx_count) begin
				state_next.mode = rpdb_pkg::RPDB_STANDBY; // see RULE_08
				state_next.tx_done = 1'b1;
			end
		end

		// Mode change by software, entries reload the pointers
		if (host_wr && (i_bus.addr == rpdb_pkg::RPDB_MODE_OFS) && code_legal(i_bus.wdata[2:0])) begin
			state_next.mode = code_mode(i_bus.wdata[2:0]);
			unique case (code_mode(i_bus.wdata[2:0]))
				rpdb_pkg::RPDB_RX_ONE, rpdb_pkg::RPDB_RX_CONT: begin
					if (!is_rx(state_reg.mode)) begin
						state_next.rx_index = state_reg.rx_start; // see RULE_03
						state_next.rx_in_pkt = 1'b0;
					end
				end
				rpdb_pkg::RPDB_TX: begin
					if (state_reg.mode != rpdb_pkg::RPDB_TX) begin
						state_next.tx_index = state_reg.tx_start; // see RULE_07
						state_next.tx_sent = 8'h00;
					end
				end
				rpdb_pkg::RPDB_SLEEP: begin
					// RAM is retained; the pointers, packet length, in-packet flag and sent count are forgotten
					state_next.tx_start = rpdb_pkg::RPDB_START_RST; // see RULE_11
					state_next.rx_start = rpdb_pkg::RPDB_START_RST;
					state_next.rx_index = 8'h00;
					state_next.tx_index = 8'h00;
					state_next.buf_ptr = 8'h00;
					state_next.rx_pkt_start = 8'h00;
					state_next.rx_len = 8'h00;
					state_next.rx_in_pkt = 1'b0;
					state_next.tx_sent = 8'h00;
				end
				default: begin
				end
			endcase
		end

		// Prefetch so the modem sees a registered byte
		state_next.tx_data = mem[state_next.tx_index];
	end

	// ****************************************
	// Registers and RAM
	// ****************************************
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= '0;
			state_reg.mode <= rpdb_pkg::RPDB_STANDBY;
			state_reg.tx_start <= rpdb_pkg::RPDB_START_RST; // see RULE_09
			state_reg.rx_start <= rpdb_pkg::RPDB_START_RST; // see RULE_09
			state_reg.tx_count <= rpdb_pkg::RPDB_COUNT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge i_clk) begin
		if (mem_we) begin
			mem[mem_waddr] <= mem_wdata; // see RULE_17
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence seq_mode_write;
		host_wr && (i_bus.addr == rpdb_pkg::RPDB_MODE_OFS) && code_legal(i_bus.wdata[2:0]);
	endsequence

	sequence seq_rx_entry;
		is_rx(state_reg.mode) && !$past(is_rx(state_reg.mode));
	endsequence

	sequence seq_tx_entry;
		(state_reg.mode == rpdb_pkg::RPDB_TX) && ($past(state_reg.mode) != rpdb_pkg::RPDB_TX);
	endsequence

	AST_NO_RAM_WRITE_ASLEEP: assert property (asleep && i_bus.addr == rpdb_pkg::RPDB_BUF_DATA_OFS // see RULE_01
		&& (host_rd || host_wr) |-> !mem_we ##1 o_rd_data == 8'h00 && state_reg.buf_ptr == $past(state_reg.buf_ptr))
		else $error("RAM touched while asleep");

	AST_RX_ENTRY_LOAD: assert property (seq_rx_entry |-> state_reg.rx_index == $past(state_reg.rx_start)) // see RULE_03
		else $error("Receive index not loaded on entry");

	AST_RX_STORE: assert property (rx_take |-> mem_we && mem_waddr == state_reg.rx_index && mem_wdata == i_rx.data) // see RULE_02
		else $error("Received byte not stored at write index");

	AST_RX_WRAP: assert property (rx_take && state_reg.rx_index == 8'hFF |=> state_reg.rx_index == 8'h00) // see RULE_06
		else $error("Receive index did not wrap");

	AST_RX_CONT_NO_RELOAD: assert property (rx_take && i_rx.last && state_reg.mode == rpdb_pkg::RPDB_RX_CONT && !host_wr
		|=> state_reg.mode == rpdb_pkg::RPDB_RX_CONT && state_reg.rx_index == $past(state_reg.rx_index) + 8'h01) // see RULE_04
		else $error("Continuous receive lost its place");

	AST_RX_LAST_PACKET: assert property (rx_take && !state_reg.rx_in_pkt && !host_wr
		|=> state_reg.rx_pkt_start == $past(state_reg.rx_index) && state_reg.rx_len == 8'h01) // see RULE_05
		else $error("Packet start not captured");

	AST_TX_ENTRY_LOAD: assert property (seq_tx_entry |-> state_reg.tx_index == $past(state_reg.tx_start)
		&& state_reg.tx_sent == 8'h00) // see RULE_07
		else $error("Transmit index not loaded on entry");

	AST_TX_STOP: assert property (state_reg.mode == rpdb_pkg::RPDB_TX && state_reg.tx_sent == state_reg.tx_count
		&& !host_wr |-> !o_tx_valid ##1 state_reg.mode == rpdb_pkg::RPDB_STANDBY && state_reg.tx_done) // see RULE_08
		else $error("Transmit ran past its count");

	AST_RESET_OFFSETS: assert property ($fell(i_rst) // see RULE_09
		|-> state_reg.tx_start == rpdb_pkg::RPDB_START_RST && state_reg.rx_start == rpdb_pkg::RPDB_START_RST)
		else $error("Start offsets not cleared by reset");

	AST_SET_OFFSET: assert property (host_wr && !asleep && i_bus.addr == rpdb_pkg::RPDB_RX_START_OFS
		|=> state_reg.rx_start == $past(i_bus.wdata)) // see RULE_10
		else $error("Receive start offset not taken");

	AST_SLEEP_CLEARS: assert property (seq_mode_write ##0 i_bus.wdata[2:0] == rpdb_pkg::RPDB_CODE_SLEEP
		|=> state_reg.buf_ptr == 8'h00 && state_reg.rx_index == 8'h00 && state_reg.tx_index == 8'h00) // see RULE_11
		else $error("Pointers survived sleep");

	AST_HOST_STEP: assert property (data_rd || data_wr // see RULE_13
		|=> state_reg.buf_ptr == $past(state_reg.buf_ptr) + 8'h01)
		else $error("Host pointer did not step");

	AST_HOST_ADDR: assert property (data_wr |-> mem_we && mem_waddr == state_reg.buf_ptr) // see RULE_12
		else $error("Host store at wrong address");

	AST_ARBITRATE: assert property (data_wr |-> !rx_take && mem_wdata == i_bus.wdata) // see RULE_17
		else $error("Host and modem both wrote the RAM");

	// ****************************************
	// Pointer, flag, mode and data checks
	// ****************************************
	sequence seq_rx_last;
		rx_take && i_rx.last && !host_wr;
	endsequence

	sequence seq_status_read;
		host_rd && (i_bus.addr == rpdb_pkg::RPDB_STATUS_OFS) && !rx_take;
	endsequence

	AST_RX_ONE_ENDS: assert property (seq_rx_last ##0 state_reg.mode == rpdb_pkg::RPDB_RX_ONE // see RULE_03
		|=> state_reg.mode == rpdb_pkg::RPDB_STANDBY)
		else $error("Single receive did not stop");

	AST_RX_DONE_FLAG: assert property (seq_rx_last |=> state_reg.rx_done && !state_reg.rx_in_pkt) // see RULE_05
		else $error("Packet end not flagged");

	AST_RX_ENTRY_FRESH: assert property (seq_rx_entry |-> !state_reg.rx_in_pkt) // see RULE_03
		else $error("Stale packet state on receive entry");

	AST_RX_COUNT_STEP: assert property (rx_take && state_reg.rx_in_pkt && !host_wr // see RULE_16
		|=> state_reg.rx_len == $past(state_reg.rx_len) + 8'h01
		&& state_reg.rx_pkt_start == $past(state_reg.rx_pkt_start))
		else $error("Packet length did not count");

	AST_STATUS_CLEAR: assert property (seq_status_read |=> !state_reg.rx_done) // see RULE_05
		else $error("Status read left receive flag set");

	AST_TX_STEP: assert property (tx_take && !host_wr // see RULE_07
		|=> state_reg.tx_index == $past(state_reg.tx_index) + 8'h01)
		else $error("Transmit index did not step");

	AST_TX_DATA: assert property (o_tx_valid && !$past(mem_we) // see RULE_07
		|-> o_tx_data == mem[state_reg.tx_index])
		else $error("Offered byte differs from RAM");

	AST_HOST_FETCH: assert property (data_rd |=> o_rd_data == $past(mem[state_reg.buf_ptr])) // see RULE_12
		else $error("Fetched byte differs from RAM");

	AST_SLEEP_OFFSETS: assert property (seq_mode_write ##0 i_bus.wdata[2:0] == rpdb_pkg::RPDB_CODE_SLEEP // see RULE_11
		|=> state_reg.tx_start == rpdb_pkg::RPDB_START_RST && state_reg.rx_start == rpdb_pkg::RPDB_START_RST)
		else $error("Start offsets survived sleep");

endmodule

// ---- rpdb_modem_model.sv ----
// Behavioural modem on the far side of the buffer's receive and transmit byte streams
`timescale 1ns/10ps
module rpdb_modem_model (
	// Clock and pacing
	input  wire logic                              i_clk,
	input  wire logic                              i_slow,
	// Receive stream into the buffer
	output rpdb_pkg::rpdb_rx_type                  o_rx,
	input  wire logic                              i_rx_ready,
	// Transmit stream out of the buffer
	input  wire logic                              i_tx_valid,
	input  wire logic [rpdb_pkg::RPDB_DATA_W-1:0]  i_tx_data,
	output logic                                   o_tx_ready
);
	// ****************************************
	// Queues filled and read by the bench
	// ****************************************
	logic [rpdb_pkg::RPDB_DATA_W-1:0] rx_q [$];
	logic                             last_q [$];
	logic [rpdb_pkg::RPDB_DATA_W-1:0] tx_got [$];
	int                               phase;

	initial begin
		o_rx = '0;
		o_tx_ready = 1'b0;
		phase = 0;
	end

	// A byte stays offered until taken; an idle data line keeps toggling so stale values never match
	always @(posedge i_clk) begin
		if (o_rx.valid && i_rx_ready) begin
			void'(rx_q.pop_front());
			void'(last_q.pop_front());
		end
		if (i_tx_valid && o_tx_ready) begin
			tx_got.push_back(i_tx_data);
		end
		phase = (phase + 1) % 4;
		o_tx_ready <= !i_slow || phase == 0;
		if (rx_q.size() > 0) begin
			o_rx <= '{valid: 1'b1, last: last_q[0], data: rx_q[0]};
		end else begin
			o_rx <= '{valid: 1'b0, last: 1'b0, data: ~o_rx.data};
		end
	end
endmodule

// ---- rpdb_pkg.sv ----
// Constants, types and register map of the radio packet data buffer
// Behaviour
// RULE_01: A 256-byte payload RAM is usable in every mode except sleep.
// RULE_02: Received payload bytes are written into the RAM from the receive start offset onward.
// RULE_03: Entering single or continuous receive loads the receive write index from the receive start offset.
// RULE_04: In continuous receive each packet follows the previous one with no reload of the write index.
// RULE_05: The receive status shows only the start and byte length of the latest packet.
// RULE_06: The receive write index wraps to address zero past the end of the RAM.
// RULE_07: Entering transmit loads the transmit read index from the transmit start offset, then it steps once per byte sent.
// RULE_08: Transmission ends when the bytes sent equal the configured transmit byte count.
// RULE_09: After reset both start offsets are 0x00.
// RULE_10: The transmit and receive start offsets are set independently anywhere in the RAM.
// RULE_11: Sleep keeps RAM contents but loses every buffer pointer.
// RULE_12: The host offset selects the first RAM byte of a store or fetch, offset zero being the first location.
// RULE_13: The host access address steps by one after each byte stored or fetched.
// RULE_14: The host sets the offset to the start of its region before each store or fetch.
// RULE_15: Received bytes are stored even when the packet check fails.
// RULE_16: A packet longer than the receive region runs on into the transmit region unprotected.
// RULE_17: The RAM is byte wide with 8-bit wrapping pointers, and host and modem accesses never corrupt each other.
package rpdb_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int RPDB_DATA_W = 8;
	localparam int RPDB_PTR_W  = 8;
	localparam int RPDB_DEPTH  = 256;
	localparam int RPDB_REG_W  = 4;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [RPDB_REG_W-1:0] RPDB_TX_START_OFS  = 4'h0;
	localparam logic [RPDB_REG_W-1:0] RPDB_RX_START_OFS  = 4'h1;
	localparam logic [RPDB_REG_W-1:0] RPDB_TX_COUNT_OFS  = 4'h2;
	localparam logic [RPDB_REG_W-1:0] RPDB_MODE_OFS      = 4'h3;
	localparam logic [RPDB_REG_W-1:0] RPDB_RX_PKT_OFS    = 4'h4;
	localparam logic [RPDB_REG_W-1:0] RPDB_RX_COUNT_OFS  = 4'h5;
	localparam logic [RPDB_REG_W-1:0] RPDB_BUF_OFS_OFS   = 4'h6;
	localparam logic [RPDB_REG_W-1:0] RPDB_BUF_DATA_OFS  = 4'h7;
	localparam logic [RPDB_REG_W-1:0] RPDB_STATUS_OFS    = 4'h8;

	// ****************************************
	// Mode codes, reset values, status fields
	// ****************************************
	localparam logic [2:0] RPDB_CODE_STANDBY = 3'h0;
	localparam logic [2:0] RPDB_CODE_RX_ONE  = 3'h1;
	localparam logic [2:0] RPDB_CODE_RX_CONT = 3'h2;
	localparam logic [2:0] RPDB_CODE_TX      = 3'h3;
	localparam logic [2:0] RPDB_CODE_SLEEP   = 3'h4;
	localparam logic [RPDB_PTR_W-1:0] RPDB_START_RST = 8'h00;
	localparam logic [RPDB_PTR_W-1:0] RPDB_COUNT_RST = 8'h00;
	localparam int RPDB_ST_TX_DONE = 3;
	localparam int RPDB_ST_RX_DONE = 4;
	localparam int RPDB_ST_IN_PKT  = 5;

	typedef enum logic [2:0] {
		RPDB_STANDBY,
		RPDB_RX_ONE,
		RPDB_RX_CONT,
		RPDB_TX,
		RPDB_SLEEP
	} rpdb_mode_type;

	typedef struct packed {
		logic                   wr;
		logic                   rd;
		logic [RPDB_REG_W-1:0]  addr;
		logic [RPDB_DATA_W-1:0] wdata;
	} rpdb_bus_type;

	typedef struct packed {
		logic                   valid;
		logic                   last;
		logic [RPDB_DATA_W-1:0] data;
	} rpdb_rx_type;

	typedef struct packed {
		rpdb_mode_type          mode;
		logic [RPDB_PTR_W-1:0]  tx_start;
		logic [RPDB_PTR_W-1:0]  rx_start;
		logic [RPDB_PTR_W-1:0]  tx_count;
		logic [RPDB_PTR_W-1:0]  rx_index;
		logic [RPDB_PTR_W-1:0]  rx_pkt_start;
		logic [RPDB_PTR_W-1:0]  rx_len;
		logic                   rx_in_pkt;
		logic                   rx_done;
		logic [RPDB_PTR_W-1:0]  tx_index;
		logic [RPDB_PTR_W-1:0]  tx_sent;
		logic                   tx_done;
		logic [RPDB_DATA_W-1:0] tx_data;
		logic [RPDB_PTR_W-1:0]  buf_ptr;
		logic [RPDB_DATA_W-1:0] rd_data;
	} rpdb_state_type;

endpackage

// ---- test_rpdb_buffer.sv ----
// Self-checking testbench of the packet data buffer against a reference memory model
`timescale 1ns/10ps
module test_rpdb_buffer;
	// ****************************************
	// Signals and reference state
	// ****************************************
	logic                             i_clk;
	logic                             i_rst;
	rpdb_pkg::rpdb_bus_type           i_bus;
	logic [rpdb_pkg::RPDB_DATA_W-1:0] o_rd_data;
	rpdb_pkg::rpdb_rx_type            rx;
	logic                             rx_ready;
	logic                             tx_valid;
	logic [rpdb_pkg::RPDB_DATA_W-1:0] tx_data;
	logic                             tx_ready;
	logic                             slow;
	logic [7:0]                       mem [256];
	logic [7:0]                       d;
	integer                           seed;
	int                               fail_count;
	int                               tests_run;

	rpdb_buffer u_rpdb_buffer (.i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rd_data(o_rd_data),
		.i_rx(rx), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data), .i_tx_ready(tx_ready));
	rpdb_modem_model u_rpdb_modem_model (.i_clk(i_clk), .i_slow(slow), .o_rx(rx), .i_rx_ready(rx_ready),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready));

	initial i_clk = 1'b0;
	always #20 i_clk = ~i_clk;

	// ****************************************
	// Bus and checking tasks
	// ****************************************
	// Read data stands in the gap cycle and is taken at its closing edge
	task automatic bus_op(input logic w, input logic [rpdb_pkg::RPDB_REG_W-1:0] a, input logic [7:0] v);
		i_bus <= '{wr: w, rd: !w, addr: a, wdata: v};
		@(posedge i_clk);
		i_bus <= '0;
		@(posedge i_clk);
		d = o_rd_data;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [rpdb_pkg::RPDB_REG_W-1:0] a, input logic [7:0] exp);
		bus_op(1'b0, a, 8'h00);
		chk(d, exp);
	endtask

	task automatic set_mode(input logic [2:0] c);
		bus_op(1'b1, rpdb_pkg::RPDB_MODE_OFS, {5'h00, c});
	endtask

	task automatic store(input logic [7:0] ofs, input int n);
		bus_op(1'b1, rpdb_pkg::RPDB_BUF_OFS_OFS, ofs);
		for (int k = 0; k < n; k++) begin
			mem[8'(ofs + k)] = 8'($random(seed));
			bus_op(1'b1, rpdb_pkg::RPDB_BUF_DATA_OFS, mem[8'(ofs + k)]);
		end
	endtask

	task automatic fetch(input logic [7:0] ofs, input int n);
		bus_op(1'b1, rpdb_pkg::RPDB_BUF_OFS_OFS, ofs);
		for (int k = 0; k < n; k++) begin
			rd_chk(rpdb_pkg::RPDB_BUF_DATA_OFS, mem[8'(ofs + k)]);
		end
	endtask

	task automatic rx_pkt(input logic [7:0] at, input int n);
		for (int k = 0; k < n; k++) begin
			mem[8'(at + k)] = 8'($random(seed));
			u_rpdb_modem_model.rx_q.push_back(mem[8'(at + k)]);
			u_rpdb_modem_model.last_q.push_back(k == n - 1);
		end
	endtask

	// Polls status until the modem queue is empty and no single-shot transfer is running
	task automatic wait_quiet();
		for (int k = 0; k < 400; k++) begin
			bus_op(1'b0, rpdb_pkg::RPDB_STATUS_OFS, 8'h00);
			if (u_rpdb_modem_model.rx_q.size() == 0 && d[2:0] !== rpdb_pkg::RPDB_CODE_TX
				&& d[2:0] !== rpdb_pkg::RPDB_CODE_RX_ONE) return;
		end
		fail_count++;
		tally_and_finish();
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge i_clk);
		fail_count++;
		tally_and_finish();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		seed = 72;
		i_rst = 1'b1;
		i_bus = '0;
		slow = 1'b0;
		fail_count = 0;
		tests_run = 0;
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(rpdb_pkg::RPDB_TX_START_OFS, 8'h00);
		rd_chk(rpdb_pkg::RPDB_RX_START_OFS, 8'h00);
		rd_chk(rpdb_pkg::RPDB_TX_COUNT_OFS, rpdb_pkg::RPDB_COUNT_RST);
		rd_chk(rpdb_pkg::RPDB_STATUS_OFS, 8'h00);
		rd_chk(4'hF, 8'h00);
		store(8'hFC, 8);
		fetch(8'hFC, 8);
		bus_op(1'b1, rpdb_pkg::RPDB_TX_START_OFS, 8'h80);
		bus_op(1'b1, rpdb_pkg::RPDB_RX_START_OFS, 8'h70);
		rd_chk(rpdb_pkg::RPDB_TX_START_OFS, 8'h80);
		rd_chk(rpdb_pkg::RPDB_RX_START_OFS, 8'h70);
		// Single packet running past the receive area into the transmit area
		rx_pkt(8'h70, 20);
		set_mode(rpdb_pkg::RPDB_CODE_RX_ONE);
		wait_quiet();
		rd_chk(rpdb_pkg::RPDB_RX_PKT_OFS, 8'h70);
		rd_chk(rpdb_pkg::RPDB_RX_COUNT_OFS, 8'h14);
		fetch(8'h70, 20);
		// Two back-to-back packets in continuous receive, the second wrapping past the top
		bus_op(1'b1, rpdb_pkg::RPDB_RX_START_OFS, 8'hF8);
		rx_pkt(8'hF8, 6);
		rx_pkt(8'hFE, 7);
		set_mode(rpdb_pkg::RPDB_CODE_RX_CONT);
		wait_quiet();
		rd_chk(rpdb_pkg::RPDB_RX_PKT_OFS, 8'hFE);
		rd_chk(rpdb_pkg::RPDB_RX_COUNT_OFS, 8'h07);
		rd_chk(rpdb_pkg::RPDB_MODE_OFS, {5'h00, rpdb_pkg::RPDB_CODE_RX_CONT});
		fetch(8'hF8, 13);
		set_mode(rpdb_pkg::RPDB_CODE_STANDBY);
		rx_pkt(8'hF8, 1);
		set_mode(rpdb_pkg::RPDB_CODE_RX_CONT);
		wait_quiet();
		rd_chk(rpdb_pkg::RPDB_RX_PKT_OFS, 8'hF8);
		set_mode(rpdb_pkg::RPDB_CODE_STANDBY);
		// Transmit twice from a wrapping region, slow then prompt sink, then an empty count
		store(8'hFD, 5);
		bus_op(1'b1, rpdb_pkg::RPDB_TX_START_OFS, 8'hFD);
		bus_op(1'b1, rpdb_pkg::RPDB_TX_COUNT_OFS, 8'h05);
		slow = 1'b1;
		for (int r = 0; r < 2; r++) begin
			u_rpdb_modem_model.tx_got.delete();
			set_mode(rpdb_pkg::RPDB_CODE_TX);
			wait_quiet();
			chk({7'h00, d[rpdb_pkg::RPDB_ST_TX_DONE]}, 8'h01);
			rd_chk(rpdb_pkg::RPDB_STATUS_OFS, 8'h00);
			chk(8'(u_rpdb_modem_model.tx_got.size()), 8'h05);
			foreach (u_rpdb_modem_model.tx_got[k]) begin
				chk(u_rpdb_modem_model.tx_got[k], mem[8'(8'hFD + k)]);
			end
			slow = 1'b0;
		end
		u_rpdb_modem_model.tx_got.delete();
		bus_op(1'b1, rpdb_pkg::RPDB_TX_COUNT_OFS, 8'h00);
		set_mode(rpdb_pkg::RPDB_CODE_TX);
		wait_quiet();
		chk(8'(u_rpdb_modem_model.tx_got.size()), 8'h00);
		// Sleep keeps contents but drops pointers; the buffer is closed meanwhile
		set_mode(rpdb_pkg::RPDB_CODE_SLEEP);
		rd_chk(rpdb_pkg::RPDB_MODE_OFS, {5'h00, rpdb_pkg::RPDB_CODE_SLEEP});
		rd_chk(rpdb_pkg::RPDB_BUF_DATA_OFS, 8'h00);
		bus_op(1'b1, rpdb_pkg::RPDB_TX_START_OFS, 8'h33);
		set_mode(rpdb_pkg::RPDB_CODE_STANDBY);
		rd_chk(rpdb_pkg::RPDB_TX_START_OFS, 8'h00);
		rd_chk(rpdb_pkg::RPDB_RX_START_OFS, 8'h00);
		fetch(8'hFD, 5);
		// Unused mode codes leave the mode alone
		set_mode(3'h5);
		rd_chk(rpdb_pkg::RPDB_MODE_OFS, 8'h00);
		// Reset mid-run brings both start offsets back while the RAM keeps its bytes
		bus_op(1'b1, rpdb_pkg::RPDB_TX_START_OFS, 8'h44);
		bus_op(1'b1, rpdb_pkg::RPDB_RX_START_OFS, 8'h55);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		rd_chk(rpdb_pkg::RPDB_TX_START_OFS, 8'h00);
		rd_chk(rpdb_pkg::RPDB_RX_START_OFS, 8'h00);
		fetch(8'hFD, 5);
		tally_and_finish();
	end
endmodule
